// *** hw/hpp_pkg.sv ***
// Package of constants and carrier types for the host parallel port pins.
package hpp_pkg;
    // Pin group widths.
    localparam int DATA_W = 8;
    localparam int SEL_W = 3;
    localparam int GPIO_W = 13;
    // Port bit positions of each pin in the general-purpose view.
    localparam int GPIO_DATA_LSB = 0;
    localparam int GPIO_SEL_LSB = 8;
    localparam int GPIO_DIR_BIT = 11;
    localparam int GPIO_STB_BIT = 12;
    // Reset values.
    localparam logic HOST_MODE_RST = 1'b0;
    localparam logic [12:0] GPIO_DIR_RST = 13'h0000;
    localparam logic [12:0] GPIO_OUT_RST = 13'h0000;
    localparam logic [7:0] DATA_RST = 8'h00;

    // One captured host write: register select and byte.
    typedef struct packed {
        logic [2:0] sel;
        logic [7:0] data;
    } hpp_wr_t;

    // Pin levels as seen at the pads.
    typedef struct packed {
        logic [7:0] data;
        logic [2:0] sel;
        logic dir;
        logic strobe_n;
    } hpp_pins_t;

    // Handshake state of the write-capture path.
    typedef enum logic [1:0] {
        HPP_IDLE = 2'b00,
        HPP_WRITE = 2'b01,
        HPP_READ = 2'b10
    } hpp_state_t;
endpackage

// *** hw/hpp_buf2.sv ***
// Two-entry valid/ready buffer for captured host writes.
`timescale 1ns/1ps
module hpp_buf2 (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire hpp_pkg::hpp_wr_t in_data,
    output logic out_valid,
    input wire logic out_ready,
    output hpp_pkg::hpp_wr_t out_data
);
    hpp_pkg::hpp_wr_t mem_reg [2];
    logic [1:0] count_reg;
    logic wr_ptr_reg;
    logic rd_ptr_reg;
    logic push;
    logic pop;

    // Honest flags: full at two entries, empty at zero.
    assign in_ready = (count_reg != 2'd2);
    assign out_valid = (count_reg != 2'd0);
    assign out_data = mem_reg[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage written by index.
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers and occupancy.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            count_reg <= 2'd0;
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 2'd1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 2'd1;
            end
        end
    end
endmodule // hpp_buf2

// *** hw/hpp_port.sv ***
// Pin multiplexer and host write capture for the host parallel port.
`timescale 1ns/1ps
module hpp_port (
    input wire logic sys_clk,
    input wire logic nrst,
    // Mode and port-bit control from the core.
    input wire logic host_mode,
    input wire logic [12:0] gpio_dir,
    input wire logic [12:0] gpio_out,
    output logic [12:0] gpio_in,
    // Core side read data and request state.
    input wire logic [7:0] read_data,
    output logic [2:0] read_select,
    input wire logic host_service_request_n,
    // Captured write stream toward the core.
    output logic wr_valid,
    input wire logic wr_ready,
    output hpp_pkg::hpp_wr_t wr_word,
    output logic wr_overrun,
    // Pads: data lines are bidirectional.
    input wire logic [7:0] host_data_lines_in,
    output logic [7:0] host_data_lines_out,
    output logic [7:0] host_data_lines_oe,
    input wire logic [2:0] host_register_select,
    input wire logic host_direction_select,
    input wire logic host_enable_strobe_n,
    input wire logic host_acknowledge_n,
    // Port-bit drive for the five control pins in port mode.
    output logic [4:0] ctrl_pins_out,
    output logic [4:0] ctrl_pins_oe
);
    logic host_mode_reg;
    logic strobe_n_prev_reg;
    hpp_pkg::hpp_state_t state_reg;
    hpp_pkg::hpp_wr_t cap_reg;
    logic cap_valid_reg;
    logic [7:0] dout_reg;
    logic [7:0] doe_reg;
    logic [4:0] cout_reg;
    logic [4:0] coe_reg;
    logic [12:0] gin_reg;
    logic [2:0] rsel_reg;
    logic ovr_reg;
    logic cap_ready;
    logic buf_valid;
    hpp_pkg::hpp_wr_t buf_word;
    logic drive_read;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            host_mode_reg <= hpp_pkg::HOST_MODE_RST;
        end else begin
            host_mode_reg <= host_mode;
        end
    end

    assign drive_read = (!host_enable_strobe_n && host_direction_select)
        || (!host_acknowledge_n && !host_service_request_n);

    // Access state follows the strobe; direction is sampled once, when the strobe is first seen low.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_reg <= hpp_pkg::HPP_IDLE;
            strobe_n_prev_reg <= 1'b1;
        end else begin
            strobe_n_prev_reg <= host_enable_strobe_n;
            case (state_reg)
                hpp_pkg::HPP_IDLE: begin
                    if (host_mode_reg && !host_enable_strobe_n) begin
                        state_reg <= host_direction_select ?
                            hpp_pkg::HPP_READ : hpp_pkg::HPP_WRITE;
                    end
                end
                hpp_pkg::HPP_WRITE,
                hpp_pkg::HPP_READ: begin
                    if (host_enable_strobe_n) begin
                        state_reg <= hpp_pkg::HPP_IDLE;
                    end
                end
                default: begin
                    state_reg <= hpp_pkg::HPP_IDLE;
                end
            endcase
        end
    end

    // capture on strobe rise
    // The byte is taken in the cycle the rising edge is seen, so the host
    // must keep data valid one clock past the edge.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cap_valid_reg <= 1'b0;
            cap_reg <= '0;
            ovr_reg <= 1'b0;
        end else begin
            ovr_reg <= 1'b0;
            if (state_reg == hpp_pkg::HPP_WRITE && host_enable_strobe_n
                && !strobe_n_prev_reg) begin
                cap_reg.sel <= host_register_select;
                cap_reg.data <= host_data_lines_in;
                cap_valid_reg <= 1'b1;
                // A write landing on a stalled, full slot is flagged.
                ovr_reg <= cap_valid_reg && !cap_ready;
            end else if (cap_ready) begin
                cap_valid_reg <= 1'b0;
            end
        end
    end

    // Two-entry buffer absorbs a stall by the core.
    hpp_buf2 u_buf (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .in_valid(cap_valid_reg),
        .in_ready(cap_ready),
        .in_data(cap_reg),
        .out_valid(buf_valid),
        .out_ready(wr_ready),
        .out_data(buf_word)
    );

    assign wr_valid = buf_valid;
    assign wr_word = buf_word;
    assign wr_overrun = ovr_reg;

    // Data line drivers for both host and port modes.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            dout_reg <= hpp_pkg::DATA_RST;
            doe_reg <= 8'h00;
        end else if (host_mode_reg) begin
            dout_reg <= read_data;
            doe_reg <= drive_read ? 8'hff : 8'h00;
        end else begin
            dout_reg <= gpio_out[hpp_pkg::GPIO_DATA_LSB +: 8];
            doe_reg <= gpio_dir[hpp_pkg::GPIO_DATA_LSB +: 8];
        end
    end

    // Control pins are inputs in host mode, port bits otherwise.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cout_reg <= 5'h00;
            coe_reg <= 5'h00;
        end else if (host_mode_reg) begin
            cout_reg <= 5'h00;
            coe_reg <= 5'h00;
        end else begin
            cout_reg[2:0] <= gpio_out[hpp_pkg::GPIO_SEL_LSB +: 3];
            coe_reg[2:0] <= gpio_dir[hpp_pkg::GPIO_SEL_LSB +: 3];
            cout_reg[3] <= gpio_out[hpp_pkg::GPIO_DIR_BIT];
            coe_reg[3] <= gpio_dir[hpp_pkg::GPIO_DIR_BIT];
            cout_reg[4] <= gpio_out[hpp_pkg::GPIO_STB_BIT];
            coe_reg[4] <= gpio_dir[hpp_pkg::GPIO_STB_BIT];
        end
    end

    // Pin levels reported back as port bits in either mode.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            gin_reg <= 13'h0000;
            rsel_reg <= 3'h0;
        end else begin
            gin_reg <= {host_enable_strobe_n, host_direction_select,
                host_register_select, host_data_lines_in};
            rsel_reg <= host_register_select;
        end
    end

    assign host_data_lines_out = dout_reg;
    assign host_data_lines_oe = doe_reg;
    assign ctrl_pins_out = cout_reg;
    assign ctrl_pins_oe = coe_reg;
    assign gpio_in = gin_reg;
    assign read_select = rsel_reg;
endmodule // hpp_port

// *** verification/hpp_checker.sv ***
// Checker for the host parallel port pin rules.
`timescale 1ns/1ps
module hpp_checker (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic host_mode,
    input wire logic [12:0] gpio_dir,
    input wire logic host_service_request_n,
    input wire logic wr_valid,
    input wire logic wr_overrun,
    input wire logic [7:0] host_data_lines_oe,
    input wire logic host_direction_select,
    input wire logic host_enable_strobe_n,
    input wire logic host_acknowledge_n,
    input wire logic [4:0] ctrl_pins_oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // Active-high views of the host pins keep the properties short.
    wire stb = !host_enable_strobe_n;
    wire rd = host_direction_select;
    wire hs = !host_acknowledge_n && !host_service_request_n;
    wire [7:0] oe = host_data_lines_oe;
    // Pin checks other than the reset check wait until the mode has been steady for two samples.
    sequence s_host; host_mode [*2]; endsequence
    sequence s_port; !host_mode [*2]; endsequence
    sequence s_wr_end; (host_mode && stb && !rd) [*2] ##1 !stb; endsequence
    a_idle_off: assert property (
        s_host ##0 (!stb && !hs) |=> oe == 8'h00) else $error("idle drive");
    a_read_drive: assert property (
        s_host ##0 (stb && rd) |=> oe == 8'hff) else $error("read drive");
    a_ack_drive: assert property (
        s_host ##0 hs |=> oe == 8'hff) else $error("ack drive");
    a_write_capture: assert property (
        s_wr_end |-> ##[1:3] (wr_valid || wr_overrun)) else $error("capture");
    a_port_data: assert property (
        s_port |=> oe == $past(gpio_dir[7:0])) else $error("port data");
    a_port_select: assert property (
        s_port |=> ctrl_pins_oe[2:0] == $past(gpio_dir[10:8]))
        else $error("port select");
    a_port_ctrl: assert property (
        s_port |=> ctrl_pins_oe[4:3] == $past(gpio_dir[12:11]))
        else $error("port ctrl");
    a_reset_inputs: assert property (
        $rose(nrst) |-> oe == 8'h00 && ctrl_pins_oe == 5'h00 && !wr_valid)
        else $error("reset drive");
endmodule // hpp_checker

bind hpp_port hpp_checker u_chk (.*);

// *** verification/hpp_host_model.sv ***
// Behavioural host that strobes byte reads and writes.
`timescale 1ns/1ps
module hpp_host_model (
    input wire logic sys_clk,
    input wire logic [7:0] dev_oe,
    input wire logic [7:0] dev_out,
    output logic [7:0] bus_in,
    output logic [2:0] sel,
    output logic dir,
    output logic strobe_n
);
    logic cs = 1'b0, ds = 1'b0, drv = 1'b0;
    logic [7:0] val = 8'h00, prev = 8'h00;
    assign strobe_n = !(cs && ds);
    // Released bits flip every cycle, so a stale byte never passes.
    assign bus_in = dev_oe & dev_out | ~dev_oe & (drv ? val : ~prev);
    // Last wire level, kept for the released-bus pattern.
    always @(posedge sys_clk) prev <= bus_in;
    // Select and direction start at a known level.
    initial {sel, dir} = 4'h0;
    task automatic xfer(logic [2:0] s, logic r, logic [7:0] d, int lo,
            output logic [7:0] q);
        @(negedge sys_clk);
        {sel, dir, val, drv, cs} = {s, r, d, !r, 1'b1};
        @(negedge sys_clk);
        ds = 1'b1;
        repeat (lo) @(negedge sys_clk);
        q = bus_in;
        ds = 1'b0;
        repeat (2) @(negedge sys_clk);
        {cs, drv} = 2'h0;
    endtask
endmodule // hpp_host_model

// *** verification/test_host_parallel_port_pins.sv ***
// Self-checking bench for the host parallel port pins.
`timescale 1ns/1ps
module test_host_parallel_port_pins;
    logic sys_clk = 1'b0, nrst = 1'b0, host_mode = 1'b0, wr_ready = 1'b0;
    logic req_n = 1'b1, ack_n = 1'b1, wr_valid, wr_overrun, dir, stb_n;
    logic [12:0] gpio_dir = 13'h0000, gpio_out = 13'h0000;
    logic [7:0] read_data = 8'h00, d_in, d_out, d_oe, q;
    logic [4:0] c_out, c_oe;
    logic [2:0] sel, rsel;
    logic [31:0] rnd = 32'h0001_1733;
    hpp_pkg::hpp_wr_t wr_word, w, exp_q[$];
    int n_mismatch = 0, n_checks = 0, n_ovr = 0;
    // Free-running 100 MHz clock.
    always #5 sys_clk = ~sys_clk;
    hpp_port dut (.sys_clk(sys_clk), .nrst(nrst), .host_mode(host_mode),
        .gpio_dir(gpio_dir), .gpio_out(gpio_out), .gpio_in(),
        .read_data(read_data), .read_select(rsel),
        .host_service_request_n(req_n), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_word(wr_word), .wr_overrun(wr_overrun),
        .host_data_lines_in(d_in), .host_data_lines_out(d_out),
        .host_data_lines_oe(d_oe), .host_register_select(sel),
        .host_direction_select(dir), .host_enable_strobe_n(stb_n),
        .host_acknowledge_n(ack_n), .ctrl_pins_out(c_out),
        .ctrl_pins_oe(c_oe));
    hpp_host_model host (.sys_clk(sys_clk), .dev_oe(d_oe), .dev_out(d_out),
        .bus_in(d_in), .sel(sel), .dir(dir), .strobe_n(stb_n));
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(string name, logic [12:0] e, logic [12:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, e, g);
        end
    endtask
    // Queue the expected word first, then let the host strobe it in.
    task automatic hw(int lo);
        rnd = lfsr(rnd);
        w = rnd[10:0];
        exp_q.push_back(w);
        host.xfer(w.sel, 1'b0, w.data, lo, q);
    endtask
    // Outputs are looked at just after release, before any new edge.
    task automatic rst_chk(int n);
        nrst = 1'b0;
        repeat (n) @(negedge sys_clk);
        nrst = 1'b1;
        #1;
        chk("oe at reset", 13'h0000, {c_oe, d_oe});
        chk("valid at reset", 13'h0000, 13'(wr_valid));
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Count dropped captures and match every delivered word in order.
    // An overrun overwrites the word still waiting in the capture stage,
    // which is the one queued just before the newest write.
    always @(posedge sys_clk) begin
        if (wr_overrun === 1'b1) begin
            n_ovr++;
            if (exp_q.size() > 1) exp_q.delete(exp_q.size() - 2);
        end
        if (wr_valid === 1'b1 && wr_ready) begin
            if (exp_q.size() == 0) chk("stray", 13'h1fff, 13'(wr_word));
            else chk("word", 13'(exp_q.pop_front()), 13'(wr_word));
        end
    end
    // Port mode first, then stalled and random host traffic.
    initial begin
        rst_chk(10);
        wr_ready = 1'b1;
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            gpio_dir = (i == 0) ? 13'h1fff : rnd[12:0];
            gpio_out = rnd[25:13];
            repeat (2) @(negedge sys_clk);
            chk("port oe", gpio_dir, {c_oe, d_oe});
            chk("port out", gpio_out, {c_out, d_out});
        end
        gpio_dir = 13'h0000;
        host.xfer(3'h5, 1'b0, 8'ha5, 2, q);
        host_mode = 1'b1;
        wr_ready = 1'b0;
        repeat (2) @(negedge sys_clk);
        for (int i = 0; i < 4; i++) hw(2);
        wr_ready = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk("lost words", 13'h0001, 13'(n_ovr));
        chk("drained", 13'h0000, 13'(exp_q.size()));
        exp_q.delete();
        for (int i = 0; i < 12; i++) begin
            rnd = lfsr(rnd);
            read_data = rnd[7:0];
            w = rnd[10:0];
            if (rnd[31]) hw(2 + int'(rnd[29:28]));
            else begin
                host.xfer(w.sel, 1'b1, 8'h00, 2 + int'(rnd[29:28]), q);
                chk("read byte", 13'(read_data), 13'(q));
                chk("read select", 13'(w.sel), 13'(rsel));
            end
        end
        {req_n, ack_n} = 2'h0;
        repeat (2) @(negedge sys_clk);
        chk("ack drive", 13'h00ff, 13'(d_oe));
        req_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk("ack alone", 13'h0000, 13'(d_oe));
        ack_n = 1'b1;
        rst_chk(2);
        tally_and_finish();
    end
    // The run needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule // test_host_parallel_port_pins
